// [logic/mmd_pkg.sv]
/*
  Constants for the indirect extended-register access block: register
  offsets, control field layout, access functions, device selectors,
  reset values and answer states.
  Assumes a 16-bit management register space of 32 direct registers.
*/
`default_nettype none

package mmd_pkg;

  // Direct register space.
  localparam int unsigned REG_ADDR_W = 5;
  localparam int unsigned DATA_W     = 16;

  localparam logic [4:0] REG_ACCESS_CONTROL = 5'h0d;
  localparam logic [4:0] REG_ADDRESS_DATA   = 5'h0e;

  // Control register fields.
  localparam int unsigned FUNC_HI  = 15;
  localparam int unsigned FUNC_LO  = 14;
  localparam int unsigned DEVAD_HI = 4;
  localparam int unsigned DEVAD_LO = 0;

  typedef enum logic [1:0] {
    FUNC_ADDRESS     = 2'h0,
    FUNC_DATA        = 2'h1,
    FUNC_DATA_INC_RW = 2'h2,
    FUNC_DATA_INC_WR = 2'h3
  } func_e;

  localparam logic [4:0] DEVAD_VENDOR = 5'h1f;
  localparam logic [4:0] DEVAD_PMA    = 5'h01;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] ADDR_STEP  = 16'h0001;
  localparam logic [15:0] READ_ZERO  = 16'h0000;

  // Answer sequencer, Gray coded along idle, fetch, answer.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_FETCH  = 2'h1,
    ST_ANSWER = 2'h3
  } state_e;

endpackage : mmd_pkg

`default_nettype wire

// [logic/mmd_ext_mem.sv]
/*
  Extended register storage: one word array holding both selectable
  device spaces, with a registered read port.
  Assumes one access per cycle from the indirect access block.
*/
`timescale 1ns/1ps
`default_nettype none

module mmd_ext_mem #(
  parameter int unsigned AW = 13,
  parameter int unsigned DW = 16
) (
  // Clock.
  input  wire logic          clock,
  // Access.
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Contents are not reset; the read register follows the array.
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule // mmd_ext_mem

`default_nettype wire

// [logic/mmd_indirect_access.sv]
/*
  Management register block: access control and address/data registers
  that reach two extended register spaces indirectly, plus the storage
  of those spaces. Every request taken while idle is answered two cycles later.
  Assumes requests are synchronous single-cycle strobes from a decoded
  management frame; other direct registers live outside this block.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Direct accesses cover only register addresses 0x0 to 0x1F.
// - Control low five bits select the space reached through 0xE.
// - Selector 11111 reaches the vendor extended space.
// - Selector 00001 reaches the attachment-layer space.
// - Other selectors: indirect access ignored, nothing changes.
// - Control bits 15:14 give the access function.
// - Function 00: 0xE reads and writes the address register.
// - Function 01: data access, address register unchanged.
// - Function 10: address increments after every read and write.
// - Function 11: address increments after writes only.
// - Direct address is the 5-bit field; 32 registers of 16 bits.
module mmd_indirect_access #(
  parameter int unsigned EXT_AW = 12
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Decoded management request.
  input  wire logic        mgmt_req,
  input  wire logic        mgmt_we,
  input  wire logic [4:0]  mgmt_reg,
  input  wire logic [15:0] mgmt_wdata,
  // Answer.
  output logic             mgmt_ack,
  output logic      [15:0] mgmt_rdata
);

  typedef struct packed {
    mmd_pkg::state_e state;
    logic [15:0]     ctrl;
    logic [15:0]     addr;
    logic            from_mem;
    logic            ack;
    logic [15:0]     rdata;
  } regs_s;

  regs_s s_q;
  regs_s s_d;

  logic              mem_we;
  logic [EXT_AW:0]   mem_addr;
  logic [15:0]       mem_rdata;
  logic [4:0]        devad;
  mmd_pkg::func_e    func;
  logic              dev_ok;
  logic              take;

  assign devad  = s_q.ctrl[mmd_pkg::DEVAD_HI:mmd_pkg::DEVAD_LO];
  assign func   = mmd_pkg::func_e'(s_q.ctrl[mmd_pkg::FUNC_HI:mmd_pkg::FUNC_LO]);
  assign dev_ok = (devad == mmd_pkg::DEVAD_VENDOR) ||
                  (devad == mmd_pkg::DEVAD_PMA);
  assign take   = mgmt_req && (s_q.state == mmd_pkg::ST_IDLE);
  assign mem_addr = {devad == mmd_pkg::DEVAD_VENDOR, s_q.addr[EXT_AW-1:0]};

  always_comb begin
    s_d        = s_q;
    s_d.ack    = 1'b0;
    mem_we     = 1'b0;
    unique case (s_q.state)
      mmd_pkg::ST_IDLE: begin
        if (mgmt_req) begin
          s_d.state    = mmd_pkg::ST_FETCH;
          s_d.from_mem = 1'b0;
          s_d.rdata    = mmd_pkg::READ_ZERO;
          if (mgmt_reg == mmd_pkg::REG_ACCESS_CONTROL) begin
            s_d.rdata = s_q.ctrl;
            if (mgmt_we) begin
              s_d.ctrl = mgmt_wdata;
            end
          end else if (mgmt_reg == mmd_pkg::REG_ADDRESS_DATA && dev_ok) begin
            if (func == mmd_pkg::FUNC_ADDRESS) begin
              s_d.rdata = s_q.addr;
              if (mgmt_we) begin
                s_d.addr = mgmt_wdata;
              end
            end else begin
              mem_we       = mgmt_we;
              s_d.from_mem = !mgmt_we;
              if (func == mmd_pkg::FUNC_DATA_INC_RW ||
                  (func == mmd_pkg::FUNC_DATA_INC_WR && mgmt_we)) begin
                s_d.addr = s_q.addr + mmd_pkg::ADDR_STEP;
              end
            end
          end
        end
      end
      mmd_pkg::ST_FETCH: begin
        // Storage read data are valid one cycle after the address.
        s_d.state = mmd_pkg::ST_ANSWER;
        s_d.ack   = 1'b1;
        if (s_q.from_mem) begin
          s_d.rdata = mem_rdata;
        end
      end
      mmd_pkg::ST_ANSWER: begin
        s_d.state = mmd_pkg::ST_IDLE;
      end
      default: begin
        s_d.state = mmd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q.state    <= mmd_pkg::ST_IDLE;
      s_q.ctrl     <= mmd_pkg::CTRL_RESET;
      s_q.addr     <= mmd_pkg::ADDR_RESET;
      s_q.from_mem <= 1'b0;
      s_q.ack      <= 1'b0;
      s_q.rdata    <= mmd_pkg::READ_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  mmd_ext_mem #(
    .AW (EXT_AW + 1),
    .DW (mmd_pkg::DATA_W)
  ) u_mem (
    .clock   (clock),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mgmt_wdata),
    .rdata_q (mem_rdata)
  );

  assign mgmt_ack   = s_q.ack;
  assign mgmt_rdata = s_q.rdata;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic sel_data;
  assign sel_data = take && mgmt_reg == mmd_pkg::REG_ADDRESS_DATA && dev_ok;

  sequence s_taken;
    take;
  endsequence
  sequence s_answer;
    !mgmt_ack ##1 mgmt_ack ##1 !mgmt_ack;
  endsequence

  property p_answer_time;
    s_taken |-> ##1 s_answer;
  endproperty
  a_answer_time: assert property (p_answer_time)
    else $error("answer not two cycles after request");

  property p_ctrl_write;
    take && mgmt_we && mgmt_reg == mmd_pkg::REG_ACCESS_CONTROL
      |=> s_q.ctrl == $past(mgmt_wdata);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control register not loaded");

  property p_addr_func_write;
    sel_data && mgmt_we && func == mmd_pkg::FUNC_ADDRESS
      |=> s_q.addr == $past(mgmt_wdata);
  endproperty
  a_addr_func_write: assert property (p_addr_func_write)
    else $error("address register not written in address function");

  property p_no_inc;
    sel_data && func == mmd_pkg::FUNC_DATA |=> $stable(s_q.addr);
  endproperty
  a_no_inc: assert property (p_no_inc)
    else $error("address moved without increment function");

  property p_inc_rw;
    sel_data && func == mmd_pkg::FUNC_DATA_INC_RW
      |=> s_q.addr == $past(s_q.addr) + mmd_pkg::ADDR_STEP;
  endproperty
  a_inc_rw: assert property (p_inc_rw)
    else $error("address not incremented after access");

  property p_inc_wr_read;
    sel_data && !mgmt_we && func == mmd_pkg::FUNC_DATA_INC_WR
      |=> $stable(s_q.addr);
  endproperty
  a_inc_wr_read: assert property (p_inc_wr_read)
    else $error("address incremented after read in write-only mode");

  property p_inc_wr_write;
    sel_data && mgmt_we && func == mmd_pkg::FUNC_DATA_INC_WR
      |=> s_q.addr == $past(s_q.addr) + mmd_pkg::ADDR_STEP;
  endproperty
  a_inc_wr_write: assert property (p_inc_wr_write)
    else $error("address not incremented after write");

  property p_bad_devad;
    take && mgmt_reg == mmd_pkg::REG_ADDRESS_DATA && !dev_ok
      |-> !mem_we ##1 $stable(s_q.addr) ##1 mgmt_rdata == mmd_pkg::READ_ZERO;
  endproperty
  a_bad_devad: assert property (p_bad_devad)
    else $error("access with unsupported selector had an effect");

  // Storage may only change on a taken data-function write through 0xE.
  property p_mem_space;
    mem_we |-> take && mgmt_we && mgmt_reg == mmd_pkg::REG_ADDRESS_DATA &&
               dev_ok && func != mmd_pkg::FUNC_ADDRESS;
  endproperty
  a_mem_space: assert property (p_mem_space)
    else $error("storage written outside a data-function write");

endmodule // mmd_indirect_access

`default_nettype wire

// [sim/mgmt_station.sv]
/* Station model that issues one-cycle register requests.
   Assumes the block acks each taken request. */
`timescale 1ns/1ps
`default_nettype none
module mgmt_station (
  // Clock and block answer.
  input  wire logic        clock,
  input  wire logic        mgmt_ack,
  input  wire logic [15:0] mgmt_rdata,
  // Request.
  output logic             mgmt_req,
  output logic             mgmt_we,
  output logic      [4:0]  mgmt_reg,
  output logic      [15:0] mgmt_wdata
);
  initial begin
    mgmt_req   = 1'b0;
    mgmt_we    = 1'b0;
    mgmt_reg   = 5'h00;
    mgmt_wdata = 16'h0000;
  end
  // Called at a rising edge; returns at the ack edge.
  task automatic xfer(input logic w, input logic [4:0] r,
                      input logic [15:0] d,
                      output logic [15:0] q, output int lat);
    mgmt_req   <= 1'b1;
    mgmt_we    <= w;
    mgmt_reg   <= r;
    mgmt_wdata <= d;
    @(posedge clock);
    mgmt_req   <= 1'b0;
    // Stale data is inverted so nothing relies on it.
    mgmt_wdata <= ~d;
    lat = 0;
    while (lat < 6 && mgmt_ack !== 1'b1) begin
      @(posedge clock);
      lat++;
    end
    q = mgmt_rdata;
  endtask
endmodule // mgmt_station
`default_nettype wire

// [sim/mmd_indirect_register_access_tb.sv]
/* Self-checking bench for the indirect register block.
   Assumes the station model makes every request. */
`timescale 1ns/1ps
`default_nettype none
module mmd_indirect_register_access_tb;
  localparam logic [4:0] cr = mmd_pkg::REG_ACCESS_CONTROL;
  localparam logic [4:0] ad = mmd_pkg::REG_ADDRESS_DATA;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        mgmt_req;
  logic        mgmt_we;
  logic        mgmt_ack;
  logic [4:0]  mgmt_reg;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata;
  logic [15:0] q;
  int          err_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          lat;
  always #10 clock = ~clock;
  mmd_indirect_access #(.EXT_AW(12)) DUT (
    .clock(clock), .rst_n(rst_n), .mgmt_req(mgmt_req),
    .mgmt_we(mgmt_we), .mgmt_reg(mgmt_reg),
    .mgmt_wdata(mgmt_wdata), .mgmt_ack(mgmt_ack),
    .mgmt_rdata(mgmt_rdata));
  mgmt_station stn (
    .clock(clock), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata),
    .mgmt_req(mgmt_req), .mgmt_we(mgmt_we), .mgmt_reg(mgmt_reg),
    .mgmt_wdata(mgmt_wdata));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Every access must be answered two cycles after it is taken.
  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    stn.xfer(1'b1, r, d, q, lat);
    check(16'(lat), 16'h0002);
  endtask
  task automatic rd(input logic [4:0] r, input logic [15:0] e);
    stn.xfer(1'b0, r, 16'h0000, q, lat);
    check(16'(lat), 16'h0002);
    check(q, e);
  endtask
  task automatic t_plain();
    rd(cr, 16'h0000);
    rd(ad, 16'h0000);
    wr(cr, 16'h001f);
    wr(ad, 16'h0462);
    rd(ad, 16'h0462);
    wr(ad, 16'h0100);
    rd(ad, 16'h0100);
    wr(cr, 16'h401f);
    rd(cr, 16'h401f);
    wr(ad, 16'ha5a5);
    wr(ad, 16'h5a5a);
    rd(ad, 16'h5a5a);
    wr(cr, 16'h001f);
    rd(ad, 16'h0100);
  endtask
  task automatic t_pma();
    wr(cr, 16'h0001);
    wr(ad, 16'h0100);
    wr(cr, 16'h4001);
    wr(ad, 16'h1234);
    rd(ad, 16'h1234);
    wr(cr, 16'h401f);
    rd(ad, 16'h5a5a);
  endtask
  task automatic t_inc_rw();
    wr(cr, 16'h001f);
    wr(ad, 16'h0020);
    wr(cr, 16'h801f);
    for (int i = 0; i < 3; i++) wr(ad, 16'hc000 + 16'(i));
    wr(cr, 16'h001f);
    rd(ad, 16'h0023);
    wr(ad, 16'h0020);
    wr(cr, 16'h801f);
    for (int i = 0; i < 3; i++) rd(ad, 16'hc000 + 16'(i));
    wr(cr, 16'h001f);
    rd(ad, 16'h0023);
  endtask
  task automatic t_inc_wr();
    wr(cr, 16'h0001);
    wr(ad, 16'h0030);
    wr(cr, 16'hc001);
    wr(ad, 16'hbeef);
    wr(ad, 16'hcafe);
    wr(cr, 16'h0001);
    wr(ad, 16'h0030);
    wr(cr, 16'hc001);
    rd(ad, 16'hbeef);
    rd(ad, 16'hbeef);
    wr(ad, 16'h1111);
    rd(ad, 16'hcafe);
  endtask
  // The address register holds 0x31 here: the last write-only increment.
  task automatic t_bad();
    wr(cr, 16'h0002);
    wr(ad, 16'h0777);
    rd(ad, 16'h0000);
    wr(cr, 16'h4002);
    wr(ad, 16'hffff);
    wr(cr, 16'h0001);
    rd(ad, 16'h0031);
    wr(ad, 16'h0031);
    wr(cr, 16'h4001);
    rd(ad, 16'hcafe);
    wr(5'h1f, 16'hffff);
    rd(5'h1f, 16'h0000);
    rd(cr, 16'h4001);
  endtask
  // A reset in mid-run must bring back address function and address zero.
  task automatic t_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(cr, 16'h0000);
    wr(cr, 16'h001f);
    rd(ad, 16'h0000);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_plain();
    t_pma();
    t_inc_rw();
    t_inc_wr();
    t_bad();
    t_reset();
    end_sim();
  end
endmodule // mmd_indirect_register_access_tb
`default_nettype wire
